//--- bench/lac_load_src.sv
// Far-side model: one load reading per full step and the coil magnitudes.
// Assumes the bench calls its tasks from a process synchronised to pclk.
`timescale 1ns/1ps

module lac_load_src (
  // Clock
  input  wire logic                    pclk,
  // Load reading and coil magnitudes
  output logic [lac_pkg::LOAD_W-1:0]   load_measure,
  output logic                         meas_valid,
  output logic [lac_pkg::COIL_W-1:0]   coil_a_in,
  output logic [lac_pkg::COIL_W-1:0]   coil_b_in
);
  initial begin
    load_measure = 10'h155;
    meas_valid   = 1'b0;
    coil_a_in    = 8'h00;
    coil_b_in    = 8'h00;
  end

  // Outside the pulse the line carries the inverse, so a stale sample shows
  task automatic send(input logic [lac_pkg::LOAD_W-1:0] l);
    @(posedge pclk);
    load_measure <= l;
    meas_valid   <= 1'b1;
    @(posedge pclk);
    load_measure <= ~l;
    meas_valid   <= 1'b0;
  endtask

  task automatic set_coil(input logic [7:0] a, input logic [7:0] b);
    @(posedge pclk);
    coil_a_in <= a;
    coil_b_in <= b;
  endtask
endmodule

//--- bench/testbench.sv
// Self-checking bench for the load-adaptive current scaler, driven over APB.
// Assumes lac_pkg, the scaler and the far-side model lac_load_src.
`timescale 1ns/1ps

module testbench;
  logic                          pclk;
  logic                          presetn;
  logic                          psel;
  logic                          penable;
  logic                          pwrite;
  logic [lac_pkg::ADDR_W-1:0]    paddr;
  logic [31:0]                   pwdata;
  logic                          pready;
  logic [31:0]                   prdata;
  logic                          pslverr;
  logic [lac_pkg::LOAD_W-1:0]    load_measure;
  logic                          meas_valid;
  logic [lac_pkg::COIL_W-1:0]    coil_a_in;
  logic [lac_pkg::COIL_W-1:0]    coil_b_in;
  logic [lac_pkg::COIL_W-1:0]    coil_a_out;
  logic [lac_pkg::COIL_W-1:0]    coil_b_out;
  logic                          stall_flag_out;
  logic [lac_pkg::SCALE_W-1:0]   actual_scale;
  logic [6:0]                    stall_threshold_bias;
  lac_pkg::lac_cfg_s             cfg;
  logic [31:0]                   rd;
  logic                          err;
  logic                          exp_stall;
  int                            n_errors;
  int                            n_checks;
  int                            exp_act;
  int                            cnt;
  int                            facc;
  int                            fcnt;
  int                            last;
  int                            cyc;
  int                            dn[4] = '{32, 8, 2, 1};

  lac_scaler lac_scaler_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata, .pslverr, .load_measure, .meas_valid, .coil_a_in, .coil_b_in,
    .coil_a_out, .coil_b_out, .stall_flag_out, .actual_scale, .stall_threshold_bias);
  lac_load_src lac_load_src_inst (.pclk, .load_measure, .meas_valid, .coil_a_in, .coil_b_in);

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_of_test();
    if (n_errors == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Hang guard: the whole run needs well under 4000 cycles
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 10000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // APB master: request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] ctrl_word(input lac_pkg::lac_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lac_pkg::LOW_LSB +: 4]  = c.low;
    w[lac_pkg::SPAN_LSB +: 4] = c.span;
    w[lac_pkg::INC_LSB +: 2]  = c.inc_step;
    w[lac_pkg::DEC_LSB +: 2]  = c.dec_rate;
    w[lac_pkg::MINC_BIT]      = c.min_quarter;
    w[lac_pkg::FILT_BIT]      = c.filt_en;
    w[lac_pkg::CSC_LSB +: 5]  = c.cur_scale;
    w[lac_pkg::BIAS_LSB +: 7] = c.bias;
    return w;
  endfunction

  // New settings pull the regulated scale into [minimum, setting]
  task automatic set_cfg();
    int mn;
    apb(1'b1, lac_pkg::CTRL_OFS, ctrl_word(cfg));
    mn = cfg.min_quarter ? cfg.cur_scale >> 2 : cfg.cur_scale >> 1;
    exp_act = exp_act > cfg.cur_scale ? cfg.cur_scale : (exp_act < mn ? mn : exp_act);
    if (!cfg.filt_en) fcnt = 0;
    if (!cfg.filt_en) facc = 0;
    repeat (2) @(posedge pclk);
    chk(actual_scale, exp_act, "clamp");
  endtask

  // One reading, with the expected regulation worked out alongside
  task automatic m(input int l);
    int v;
    int lo;
    int hi;
    int mn;
    lac_load_src_inst.send(l[9:0]);
    lo = int'(cfg.low) << lac_pkg::THR_SH;
    hi = (int'(cfg.low) + int'(cfg.span) + 1) << lac_pkg::THR_SH;
    mn = cfg.min_quarter ? cfg.cur_scale >> 2 : cfg.cur_scale >> 1;
    v = l;
    if (cfg.filt_en) begin
      facc += l;
      fcnt++;
      v = facc >> 2;
    end
    if (!cfg.filt_en || fcnt == 4) begin
      facc = 0;
      fcnt = 0;
      last = v;
      exp_stall = (v == 0);
      if (v < lo) begin
        cnt = 0;
        exp_act = exp_act + (1 << cfg.inc_step);
        if (exp_act > cfg.cur_scale) exp_act = cfg.cur_scale;
      end else if (v >= hi) begin
        cnt++;
        if (cnt >= dn[cfg.dec_rate]) begin
          cnt = 0;
          if (exp_act > mn) exp_act--;
        end
      end
    end
    repeat (3) @(posedge pclk);
    chk(actual_scale, exp_act, "scale");
    chk(stall_flag_out, exp_stall, "stall");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {n_errors, n_checks, cnt, facc, fcnt, last} = '0;
    exp_stall = 1'b0;
    exp_act = 31;
    cfg = '0;
    cfg.cur_scale = lac_pkg::CSC_RST;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lac_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rd, ctrl_word(cfg), "ctrl reset");
    chk(actual_scale, 32'h0000_001F, "scale reset");
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped read data");
    chk(err, 32'h0000_0001, "unmapped read error");
    // Setting 20 sits in the precise range software is advised to use
    cfg.low = 4'h4;
    cfg.span = 4'h1;
    cfg.dec_rate = 2'h3;
    cfg.cur_scale = 5'h14;
    set_cfg();
    m(191);
    m(192);
    repeat (12) m(1000);
    for (int c = 0; c < 4; c++) begin
      cfg.inc_step = c[1:0];
      set_cfg();
      m(127);
    end
    m(0);
    m(500);
    for (int c = 0; c < 3; c++) begin
      cfg.dec_rate = c[1:0];
      set_cfg();
      repeat (dn[c]) m(1000);
    end
    m(1000);
    m(100);
    m(1000);
    m(150);
    m(1000);
    cfg.min_quarter = 1'b1;
    cfg.dec_rate = 2'h3;
    set_cfg();
    repeat (20) m(1000);
    apb(1'b0, lac_pkg::STATUS_OFS, 32'h0000_0000);
    chk(rd, exp_act | (last << lac_pkg::LOAD_LSB), "status");
    lac_load_src_inst.set_coil(8'hC8, 8'h64);
    repeat (3) @(posedge pclk);
    chk(coil_a_out, (200 * (exp_act + 1)) >> 5, "coil a");
    chk(coil_b_out, (100 * (exp_act + 1)) >> 5, "coil b");
    cfg.filt_en = 1'b1;
    set_cfg();
    m(0);
    m(0);
    m(0);
    m(400);
    cfg.bias = 7'h45;
    set_cfg();
    chk(stall_threshold_bias, 32'h0000_0045, "bias");
    apb(1'b1, 12'hFFC, 32'hFFFF_FFFF);
    chk(err, 32'h0000_0001, "unmapped write error");
    apb(1'b1, lac_pkg::STATUS_OFS, 32'hFFFF_FFFF);
    chk(err, 32'h0000_0000, "status write error");
    apb(1'b0, lac_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rd, ctrl_word(cfg), "ctrl readback");
    // Mid-run reset: outputs must show reset values at the first edge after release
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(actual_scale, 32'h0000_001F, "scale after reset");
    chk(coil_a_out, 32'h0000_0000, "coil after reset");
    chk(stall_flag_out, 32'h0000_0000, "stall after reset");
    chk(stall_threshold_bias, 32'h0000_0000, "bias after reset");
    cfg = '0;
    cfg.cur_scale = lac_pkg::CSC_RST;
    apb(1'b0, lac_pkg::CTRL_OFS, 32'h0000_0000);
    chk(rd, ctrl_word(cfg), "ctrl after reset");
    end_of_test();
  end
endmodule

//--- src/lac_pkg.sv
// Package for the load-adaptive current scaler: register map, field layout,
// reset values and the configuration carrier.
// Assumes a 32-bit APB slave decode on pclk and a 10-bit load measurement.
package lac_pkg;

  localparam int unsigned LOAD_W  = 10;
  localparam int unsigned SCALE_W = 5;
  localparam int unsigned COIL_W  = 8;
  localparam int unsigned ADDR_W  = 12;
  localparam int unsigned THR_SH  = 5;  // Threshold codes are scaled by 32
  localparam int unsigned FILT_N  = 4;  // Measurements averaged in filter mode

  // Register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;

  // Control word field positions
  localparam int unsigned LOW_LSB  = 0;
  localparam int unsigned SPAN_LSB = 4;
  localparam int unsigned INC_LSB  = 8;
  localparam int unsigned DEC_LSB  = 10;
  localparam int unsigned MINC_BIT = 12;
  localparam int unsigned FILT_BIT = 13;
  localparam int unsigned CSC_LSB  = 16;
  localparam int unsigned BIAS_LSB = 24;

  // Status word field positions
  localparam int unsigned ACT_LSB   = 0;
  localparam int unsigned STALL_BIT = 8;
  localparam int unsigned LOAD_LSB  = 16;

  // Reset values
  localparam logic [3:0]         LOW_RST  = 4'h0;
  localparam logic [3:0]         SPAN_RST = 4'h0;
  localparam logic [1:0]         INC_RST  = 2'h0;
  localparam logic [1:0]         DEC_RST  = 2'h0;
  localparam logic [SCALE_W-1:0] CSC_RST  = 5'h1F;
  localparam logic [6:0]         BIAS_RST = 7'h00;

  typedef struct packed {
    logic [6:0]         bias;
    logic [SCALE_W-1:0] cur_scale;
    logic               filt_en;
    logic               min_quarter;
    logic [1:0]         dec_rate;
    logic [1:0]         inc_step;
    logic [3:0]         span;
    logic [3:0]         low;
  } lac_cfg_s;

endpackage

//--- src/lac_scaler.sv
// Load-adaptive coil current scaler with stall flag and APB register port.
// Assumes load_measure is valid with a one-cycle meas_valid pulse per full
// step, and coil magnitudes come from the sine table or serial port upstream.
`timescale 1ns/1ps

module lac_scaler (
  // APB
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         psel,
  input  wire logic                         penable,
  input  wire logic                         pwrite,
  input  wire logic [lac_pkg::ADDR_W-1:0]   paddr,
  input  wire logic [31:0]                  pwdata,
  output logic                              pready,
  output logic [31:0]                       prdata,
  output logic                              pslverr,
  // Load measurement
  input  wire logic [lac_pkg::LOAD_W-1:0]   load_measure,
  input  wire logic                         meas_valid,
  // Coil current magnitudes
  input  wire logic [lac_pkg::COIL_W-1:0]   coil_a_in,
  input  wire logic [lac_pkg::COIL_W-1:0]   coil_b_in,
  output logic [lac_pkg::COIL_W-1:0]        coil_a_out,
  output logic [lac_pkg::COIL_W-1:0]        coil_b_out,
  // Status and measurement control
  output logic                              stall_flag_out,
  output logic [lac_pkg::SCALE_W-1:0]       actual_scale,
  output logic [6:0]                        stall_threshold_bias
);

  //////////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state: pready rises in the second access cycle

  lac_pkg::lac_cfg_s cfg_r, cfg_nxt;
  logic              pready_r, pready_nxt;
  logic [31:0]       prdata_r, prdata_nxt;
  logic              pslverr_r, pslverr_nxt;
  logic              stall_r, stall_nxt;
  logic [lac_pkg::LOAD_W-1:0]  ld_val_r, ld_val_nxt;
  logic [lac_pkg::SCALE_W-1:0] act_r, act_nxt;

  logic acc_ph;
  logic hit_ctrl;
  logic hit_stat;
  assign acc_ph   = psel & penable;
  assign hit_ctrl = (paddr == lac_pkg::CTRL_OFS);
  assign hit_stat = (paddr == lac_pkg::STATUS_OFS);

  function automatic logic [31:0] ctrl_word(input lac_pkg::lac_cfg_s c);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[lac_pkg::LOW_LSB +: 4]  = c.low;
    w[lac_pkg::SPAN_LSB +: 4] = c.span;
    w[lac_pkg::INC_LSB +: 2]  = c.inc_step;
    w[lac_pkg::DEC_LSB +: 2]  = c.dec_rate;
    w[lac_pkg::MINC_BIT]      = c.min_quarter;
    w[lac_pkg::FILT_BIT]      = c.filt_en;
    w[lac_pkg::CSC_LSB +: 5]  = c.cur_scale;
    w[lac_pkg::BIAS_LSB +: 7] = c.bias;
    return w;
  endfunction

  always_comb begin
    pready_nxt  = acc_ph & ~pready_r;
    prdata_nxt  = prdata_r;
    pslverr_nxt = 1'b0;
    cfg_nxt     = cfg_r;
    if (acc_ph & ~pready_r) begin
      pslverr_nxt = ~(hit_ctrl | hit_stat);
      prdata_nxt  = 32'h0000_0000;
      if (!pwrite && hit_ctrl) begin
        prdata_nxt = ctrl_word(cfg_r);
      end else if (!pwrite && hit_stat) begin
        prdata_nxt[lac_pkg::ACT_LSB +: 5]   = act_r;
        prdata_nxt[lac_pkg::STALL_BIT]      = stall_r;
        prdata_nxt[lac_pkg::LOAD_LSB +: 10] = ld_val_r;
      end
    end
    // Write lands on the edge where pready is sampled high
    if (acc_ph && pready_r && pwrite && hit_ctrl) begin
      cfg_nxt.low         = pwdata[lac_pkg::LOW_LSB +: 4];
      cfg_nxt.span        = pwdata[lac_pkg::SPAN_LSB +: 4];
      cfg_nxt.inc_step    = pwdata[lac_pkg::INC_LSB +: 2];
      cfg_nxt.dec_rate    = pwdata[lac_pkg::DEC_LSB +: 2];
      cfg_nxt.min_quarter = pwdata[lac_pkg::MINC_BIT];
      cfg_nxt.filt_en     = pwdata[lac_pkg::FILT_BIT];
      cfg_nxt.cur_scale   = pwdata[lac_pkg::CSC_LSB +: 5];
      cfg_nxt.bias        = pwdata[lac_pkg::BIAS_LSB +: 7];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r          <= 1'b0;
      prdata_r          <= 32'h0000_0000;
      pslverr_r         <= 1'b0;
      cfg_r.low         <= lac_pkg::LOW_RST;
      cfg_r.span        <= lac_pkg::SPAN_RST;
      cfg_r.inc_step    <= lac_pkg::INC_RST;
      cfg_r.dec_rate    <= lac_pkg::DEC_RST;
      cfg_r.min_quarter <= 1'b0;
      cfg_r.filt_en     <= 1'b0;
      cfg_r.cur_scale   <= lac_pkg::CSC_RST;
      cfg_r.bias        <= lac_pkg::BIAS_RST;
    end else begin
      pready_r  <= pready_nxt;
      prdata_r  <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
      cfg_r     <= cfg_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Measurement path: pass-through or four-sample average

  logic [1:0]  filt_cnt_r, filt_cnt_nxt;
  logic [11:0] acc_r, acc_nxt;
  logic        upd_r, upd_nxt;
  logic [11:0] acc_sum;
  assign acc_sum = acc_r + {2'b00, load_measure};

  always_comb begin
    filt_cnt_nxt = filt_cnt_r;
    acc_nxt      = acc_r;
    upd_nxt      = 1'b0;
    ld_val_nxt   = ld_val_r;
    if (meas_valid) begin
      if (cfg_r.filt_en) begin
        filt_cnt_nxt = filt_cnt_r + 2'd1;
        acc_nxt      = acc_sum;
        if (filt_cnt_r == 2'd3) begin
          upd_nxt    = 1'b1;
          ld_val_nxt = acc_sum[11:2];
          acc_nxt    = 12'h000;
        end
      end else begin
        upd_nxt      = 1'b1;
        ld_val_nxt   = load_measure;
        filt_cnt_nxt = 2'd0;
        acc_nxt      = 12'h000;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      filt_cnt_r <= 2'd0;
      acc_r      <= 12'h000;
      upd_r      <= 1'b0;
      ld_val_r   <= 10'h000;
    end else begin
      filt_cnt_r <= filt_cnt_nxt;
      acc_r      <= acc_nxt;
      upd_r      <= upd_nxt;
      ld_val_r   <= ld_val_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Regulator

  logic [10:0] low_thr;
  logic [10:0] up_thr;
  logic        below;
  logic        above;
  logic [5:0]  step;
  logic [5:0]  dec_n;
  logic [4:0]  min_lim;
  logic [5:0]  inc_sum;
  logic [5:0]  dcnt_r, dcnt_nxt;
  logic [4:0]  cand;

  // Code of at most 15 scaled by 32 tops out at 480, below half of 1024
  assign low_thr = {7'h00, cfg_r.low} << lac_pkg::THR_SH;
  assign up_thr  = 11'(({1'b0, cfg_r.low} + {1'b0, cfg_r.span} + 5'd1)) << lac_pkg::THR_SH;
  assign below   = {1'b0, ld_val_r} < low_thr;
  assign above   = {1'b0, ld_val_r} >= up_thr;
  assign step    = 6'd1 << cfg_r.inc_step;
  assign min_lim = cfg_r.min_quarter ? (cfg_r.cur_scale >> 2)
                                     : (cfg_r.cur_scale >> 1);
  assign inc_sum = {1'b0, act_r} + step;

  always_comb begin
    case (cfg_r.dec_rate)
      2'd0:    dec_n = 6'd32;
      2'd1:    dec_n = 6'd8;
      2'd2:    dec_n = 6'd2;
      default: dec_n = 6'd1;
    endcase
  end

  always_comb begin
    cand     = act_r;
    dcnt_nxt = dcnt_r;
    if (upd_r) begin
      if (below) begin
        dcnt_nxt = 6'd0;
        // Saturate rather than wrap past the ceiling
        cand = (inc_sum > {1'b0, cfg_r.cur_scale}) ? cfg_r.cur_scale
                                                   : inc_sum[4:0];
      end else if (above) begin
        if (dcnt_r + 6'd1 >= dec_n) begin
          dcnt_nxt = 6'd0;
          cand     = (act_r <= min_lim) ? min_lim : act_r - 5'd1;
        end else begin
          dcnt_nxt = dcnt_r + 6'd1;
        end
      end
    end
    // A setting change can move the window; pull the value back inside
    act_nxt = cand;
    if (act_nxt > cfg_r.cur_scale) begin
      act_nxt = cfg_r.cur_scale;
    end
    if (act_nxt < min_lim) begin
      act_nxt = min_lim;
    end
    stall_nxt = upd_r ? (ld_val_r == 10'h000) : stall_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_r   <= lac_pkg::CSC_RST;
      dcnt_r  <= 6'd0;
      stall_r <= 1'b0;
    end else begin
      act_r   <= act_nxt;
      dcnt_r  <= dcnt_nxt;
      stall_r <= stall_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Coil scaling by (scale + 1) / 32

  localparam int unsigned COILP = lac_pkg::COIL_W + 6;
  logic [COILP-1:0] prod_a;
  logic [COILP-1:0] prod_b;
  logic [lac_pkg::COIL_W-1:0] coil_a_r, coil_a_nxt;
  logic [lac_pkg::COIL_W-1:0] coil_b_r, coil_b_nxt;

  always_comb begin
    prod_a     = {6'd0, coil_a_in} * {9'd0, act_r} + {6'd0, coil_a_in};
    prod_b     = {6'd0, coil_b_in} * {8'd0, 1'b0, act_r} + {6'd0, coil_b_in};
    coil_a_nxt = prod_a[lac_pkg::COIL_W+4:5];
    coil_b_nxt = prod_b[lac_pkg::COIL_W+4:5];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coil_a_r <= 8'h00;
      coil_b_r <= 8'h00;
    end else begin
      coil_a_r <= coil_a_nxt;
      coil_b_r <= coil_b_nxt;
    end
  end

  assign pready               = pready_r;
  assign prdata               = prdata_r;
  assign pslverr              = pslverr_r;
  assign coil_a_out           = coil_a_r;
  assign coil_b_out           = coil_b_r;
  assign stall_flag_out       = stall_r;
  assign actual_scale         = act_r;
  assign stall_threshold_bias = cfg_r.bias;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_last_above;
    upd_r && !below && above && (dcnt_r + 6'd1 >= dec_n);
  endsequence

  sequence s_below;
    upd_r && below;
  endsequence

  a_stall_zero_load: assert property (
    upd_r |=> (stall_flag_out == ($past(ld_val_r) == 10'h000)))
    else $error("stall flag does not follow zero load");

  a_inc_step_size: assert property (
    s_below ##0 ({1'b0, act_r} + step <= {1'b0, cfg_r.cur_scale}) ##1 $stable(cfg_r)
      |-> actual_scale == $past(act_r) + $past(step[4:0]))
    else $error("increment width wrong");

  a_dec_after_count: assert property (
    s_last_above ##0 (act_r > min_lim) ##1 $stable(cfg_r)
      |-> actual_scale == $past(act_r) - 5'd1)
    else $error("decrement missing after count");

  a_dec_too_soon: assert property (
    upd_r && above && !below && (dcnt_r + 6'd1 < dec_n) ##1 $stable(cfg_r)
      |-> $stable(actual_scale))
    else $error("decrement before count reached");

  a_below_clears: assert property (
    s_below |=> dcnt_r == 6'd0)
    else $error("above count not cleared");

  a_mid_hold: assert property (
    upd_r && !below && !above ##1 $stable(cfg_r) |-> $stable(actual_scale))
    else $error("scale moved between thresholds");

  a_scale_ceiling: assert property (
    $stable(cfg_r) |-> actual_scale <= cfg_r.cur_scale)
    else $error("scale above setting");

  a_scale_floor: assert property (
    $stable(cfg_r) |-> actual_scale >= min_lim)
    else $error("scale below minimum");

  a_unfilt_rate: assert property (
    meas_valid && !cfg_r.filt_en |=> upd_r ##1 (!upd_r || $past(meas_valid)))
    else $error("unfiltered update missing");

  a_filt_rate: assert property (
    meas_valid && cfg_r.filt_en && filt_cnt_r != 2'd3 |=> !upd_r)
    else $error("filtered update too early");

  a_coil_scale: assert property (
    presetn |=> coil_a_out == 8'(({6'd0, $past(coil_a_in)} * ({9'd0, $past(act_r)} + 14'd1)) >> 5))
    else $error("coil scaling wrong");

endmodule
